// *** design/fcr_pkg.sv ***
package fcr_pkg;
  // Source selections for the process value and the setpoint.
  typedef enum logic [2:0] {
    FCR_SRC_FIRST_INPUT_VALUE,
    FCR_SRC_SECOND_INPUT_VALUE,
    FCR_SRC_DIFF_ONE_MINUS_TWO,
    FCR_SRC_DIFF_TWO_MINUS_ONE,
    FCR_SRC_OTHER
  } fcr_src_e;

  localparam logic [2:0] FCR_SEL_FIRST = 3'h0;
  localparam logic [2:0] FCR_SEL_SECOND = 3'h1;
  localparam logic [2:0] FCR_SEL_DIFF12 = 3'h2;
  localparam logic [2:0] FCR_SEL_DIFF21 = 3'h3;

  // Secondary output function codes.
  localparam logic [2:0] FCR_SECONDARY_OUTPUT_FUNCTION_COOLING = 3'h1;
  localparam logic [2:0] FCR_SECONDARY_OUTPUT_FUNCTION_ALARM2 = 3'h2;

  // Alarm function codes.
  localparam logic [3:0] FCR_ALM_NONE = 4'h0;
  localparam logic [3:0] FCR_ALM_DWELL_TIMER = 4'h1;
  localparam logic [3:0] FCR_ALM_DIFF_HIGH = 4'h2;
  localparam logic [3:0] FCR_ALM_DIFF_LOW = 4'h3;
  localparam logic [3:0] FCR_ALM_SUM_HIGH = 4'h4;
  localparam logic [3:0] FCR_ALM_SUM_LOW = 4'h5;

  // Error codes as presented to the display and the remote master.
  localparam logic [7:0] FCR_ERR_NONE = 8'h00;
  localparam logic [7:0] FCR_ERR_PV_SP_FIRST = 8'h01;
  localparam logic [7:0] FCR_ERR_PV_SP_SECOND = 8'h02;
  localparam logic [7:0] FCR_ERR_PV_DIFF = 8'h03;
  localparam logic [7:0] FCR_ERR_COOLING = 8'h04;
  localparam logic [7:0] FCR_ERR_UNITS = 8'h05;
  localparam logic [7:0] FCR_ERR_ALARM2_NONE = 8'h06;
  localparam logic [7:0] FCR_ERR_DWELL_BOTH = 8'h07;
  localparam logic [7:0] FCR_ERR_COMM_FUNC = 8'h0a;
  localparam logic [7:0] FCR_ERR_COMM_RANGE = 8'h0b;
  localparam logic [7:0] FCR_ERR_COMM_MISSING = 8'h0c;
  localparam logic [7:0] FCR_ERR_COMM_READONLY = 8'h0e;
  localparam logic [7:0] FCR_ERR_COMM_VALUE = 8'h0f;
  localparam logic [7:0] FCR_ERR_TUNE_FAIL = 8'h1a;
  localparam logic [7:0] FCR_ERR_NVM_WRITE = 8'h1d;
  localparam logic [7:0] FCR_ERR_SENSOR2 = 8'h26;
  localparam logic [7:0] FCR_ERR_SENSOR1 = 8'h27;
  localparam logic [7:0] FCR_ERR_ADC = 8'h28;

  // Measurement modes and thresholds (raw counts: uA and mV).
  localparam logic [1:0] FCR_MODE_OPEN_DETECT = 2'h0;
  localparam logic [1:0] FCR_MODE_CURRENT_4_20 = 2'h1;
  localparam logic [1:0] FCR_MODE_VOLT_1_5 = 2'h2;
  localparam logic [1:0] FCR_MODE_NO_DETECT = 2'h3;
  localparam logic [15:0] FCR_MIN_CURRENT_UA = 16'h03e8;
  localparam logic [15:0] FCR_MIN_VOLT_MV = 16'h00fa;

  // Sensor break must be reported within this time.
  localparam int FCR_BREAK_RESPONSE_MS = 500;
  localparam int FCR_CLK_HZ = 25000000;
  localparam int FCR_BREAK_CYCLES = FCR_CLK_HZ / 1000 * FCR_BREAK_RESPONSE_MS;
  // Debounce is a fraction of the limit so detection stays well inside it.
  localparam int FCR_BREAK_FILTER_CYCLES = FCR_BREAK_CYCLES / 4;

  // Communication request function codes and register map.
  localparam logic [7:0] FCR_FUNC_READ = 8'h03;
  localparam logic [7:0] FCR_FUNC_WRITE = 8'h06;
  localparam logic [7:0] FCR_FUNC_WRITE_MULTI = 8'h10;
  localparam logic [15:0] FCR_REG_LAST = 16'h007f;
endpackage

// *** design/fcr_break_detect.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcr_break_detect #(
  parameter int FILTER_CYCLES = fcr_pkg::FCR_BREAK_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Measurement
  input wire logic [1:0] mode,
  input wire logic [15:0] level,
  input wire logic open_circuit,
  // Result
  output logic broken
);
  import fcr_pkg::*;

  localparam int CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(FILTER_CYCLES);

  logic [CW-1:0] count;
  wire raw_fault;

  assign raw_fault = (mode == FCR_MODE_OPEN_DETECT) ? open_circuit :
                     (mode == FCR_MODE_CURRENT_4_20) ? (level < FCR_MIN_CURRENT_UA) :
                     (mode == FCR_MODE_VOLT_1_5) ? (level < FCR_MIN_VOLT_MV) : 1'b0;

  // A brief dip is ignored; a fault held for the filter time is declared.
  always_ff @(posedge sys_clk) begin
    if (rst || !raw_fault) begin
      count <= '0;
    end else if (count != LIMIT) begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      broken <= 1'b0;
    end else begin
      broken <= raw_fault && (count == LIMIT);
    end
  end
endmodule
`default_nettype wire

// *** design/fcr_comm_check.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcr_comm_check #(
  parameter logic [15:0] REG_LAST = fcr_pkg::FCR_REG_LAST
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request from the remote master
  input wire logic req_valid,
  input wire logic [7:0] req_function,
  input wire logic [15:0] req_address,
  input wire logic req_is_write,
  input wire logic reg_exists,
  input wire logic reg_read_only,
  input wire logic reg_protected,
  input wire logic value_in_range,
  // Verdict
  output logic resp_valid,
  output logic write_enable,
  output logic [7:0] resp_code
);
  import fcr_pkg::*;

  wire func_ok;
  wire [7:0] next_resp_code;

  assign func_ok = (req_function == FCR_FUNC_READ) || (req_function == FCR_FUNC_WRITE) ||
                   (req_function == FCR_FUNC_WRITE_MULTI);
  assign next_resp_code =
    !func_ok ? FCR_ERR_COMM_FUNC :
    (req_address > REG_LAST) ? FCR_ERR_COMM_RANGE :
    !reg_exists ? FCR_ERR_COMM_MISSING :
    (req_is_write && (reg_read_only || reg_protected)) ? FCR_ERR_COMM_READONLY :
    (req_is_write && !value_in_range) ? FCR_ERR_COMM_VALUE : FCR_ERR_NONE;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      resp_valid <= 1'b0;
      write_enable <= 1'b0;
      resp_code <= FCR_ERR_NONE;
    end else begin
      resp_valid <= req_valid;
      // Target is committed only when every check passed.
      write_enable <= req_valid && req_is_write && (next_resp_code == FCR_ERR_NONE);
      resp_code <= req_valid ? next_resp_code : FCR_ERR_NONE;
    end
  end

  a_bad_write_blocked: assert property (@(posedge sys_clk) disable iff (rst)
    resp_valid && (resp_code == FCR_ERR_COMM_READONLY || resp_code == FCR_ERR_COMM_VALUE)
    |-> !write_enable) else $error("rejected write was committed");
  a_function_check: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && !func_ok |=> resp_valid && resp_code == FCR_ERR_COMM_FUNC)
    else $error("bad function code not flagged");
  a_range_check: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && func_ok && req_address > REG_LAST |=> resp_code == FCR_ERR_COMM_RANGE)
    else $error("out of range address not flagged");
endmodule
`default_nettype wire

// *** design/fcr_fault_code_reporter.sv ***
// Functional notes
// - Code 1 when process value and setpoint both use the first input.
// - Code 2 when process value and setpoint both use the second input.
// - Code 3 when PV is an input difference and setpoint a single input.
// - Code 4 when cooling on secondary with direct primary or any zero proportional band or integral time.
// - Code 5 on unit or decimal mismatch while both inputs are combined.
// - Code 6 when secondary output is alarm 2 but alarm 2 is none.
// - Secondary output does no alarm action when alarm 2 is none.
// - Code 7 when dwell timer chosen for both alarm functions.
// - Comm code 10 on unsupported function code.
// - Comm code 11 on register address out of range.
// - Comm code 12 on access to a non-existent parameter.
// - Comm code 14 and no write on read-only or protected register.
// - Comm code 15 and no write on out-of-range value.
// - Code 26 when auto-tuning fails or yields out-of-range PID values.
// - Code 29 when a nonvolatile write fails.
// - Code 38 on second input break or under-range current or voltage.
// - Code 39 on first input break or under-range current or voltage.
// - Code 40 on converter malfunction.
// - Second input break detected within half a second.
`timescale 1ns/1ns
`default_nettype none
module fcr_fault_code_reporter #(
  parameter int BREAK_FILTER_CYCLES = fcr_pkg::FCR_BREAK_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Source selections
  input wire logic [2:0] process_value_source_select,
  input wire logic [2:0] setpoint_source_select,
  // Output setup
  input wire logic [2:0] primary_output_function,
  input wire logic primary_direct_action_choice,
  input wire logic [2:0] secondary_output_function,
  input wire logic [15:0] proportional_band_a,
  input wire logic [15:0] proportional_band_b,
  input wire logic [15:0] integral_time_a,
  input wire logic [15:0] integral_time_b,
  // Units and alarms
  input wire logic [3:0] first_input_unit,
  input wire logic [3:0] second_input_unit,
  input wire logic [1:0] first_input_decimal_point,
  input wire logic [1:0] second_input_decimal_point,
  input wire logic [3:0] first_alarm_function,
  input wire logic [3:0] second_alarm_function,
  input wire logic second_alarm_active,
  // Tuning and nonvolatile store events
  input wire logic tune_done,
  input wire logic tune_failed,
  input wire logic tune_pid_out_of_range,
  input wire logic nvm_write_done,
  input wire logic nvm_write_ok,
  // Measurement front end
  input wire logic [1:0] first_measurement_input_mode,
  input wire logic [15:0] first_measurement_input_level,
  input wire logic first_measurement_input_open,
  input wire logic [1:0] second_measurement_input_mode,
  input wire logic [15:0] second_measurement_input_level,
  input wire logic second_measurement_input_open,
  input wire logic adc_fault,
  // Communication request
  input wire logic req_valid,
  input wire logic [7:0] req_function,
  input wire logic [15:0] req_address,
  input wire logic req_is_write,
  input wire logic reg_exists,
  input wire logic reg_read_only,
  input wire logic reg_protected,
  input wire logic value_in_range,
  // Communication verdict
  output logic comm_resp_valid,
  output logic comm_write_enable,
  output logic [7:0] comm_error_code,
  // Status outputs
  output logic secondary_alarm_drive,
  output logic [7:0] error_code,
  output logic error_active,
  // Clears the latched tuning and nonvolatile failures
  input wire logic fault_ack
);
  import fcr_pkg::*;

  wire alarm_diff_a;
  wire alarm_diff_b;
  wire both_inputs_used;
  wire cooling_sel;
  wire [15:0] cond;
  wire first_broken;
  wire second_broken;
  wire [7:0] next_error_code;
  logic tune_fault;
  logic nvm_fault;
  logic [23:0] second_open_age;

  // Decoding used for both alarm functions.
  function automatic logic uses_both(input logic [3:0] fn);
    uses_both = (fn == FCR_ALM_DIFF_HIGH) || (fn == FCR_ALM_DIFF_LOW) ||
                (fn == FCR_ALM_SUM_HIGH) || (fn == FCR_ALM_SUM_LOW);
  endfunction

  assign alarm_diff_a = uses_both(first_alarm_function);
  assign alarm_diff_b = uses_both(second_alarm_function);
  assign both_inputs_used = (process_value_source_select == FCR_SEL_DIFF12) ||
                            (process_value_source_select == FCR_SEL_DIFF21) ||
                            (setpoint_source_select == FCR_SEL_FIRST) ||
                            (setpoint_source_select == FCR_SEL_SECOND) ||
                            alarm_diff_a || alarm_diff_b;
  assign cooling_sel = (secondary_output_function == FCR_SECONDARY_OUTPUT_FUNCTION_COOLING);

  assign cond[0] = (process_value_source_select == FCR_SEL_FIRST) &&
                   (setpoint_source_select == FCR_SEL_FIRST);
  assign cond[1] = (process_value_source_select == FCR_SEL_SECOND) &&
                   (setpoint_source_select == FCR_SEL_SECOND);
  assign cond[2] = ((process_value_source_select == FCR_SEL_DIFF12) ||
                    (process_value_source_select == FCR_SEL_DIFF21)) &&
                   ((setpoint_source_select == FCR_SEL_FIRST) ||
                    (setpoint_source_select == FCR_SEL_SECOND));
  assign cond[3] = cooling_sel && (primary_direct_action_choice ||
                   (proportional_band_a == 16'h0000) || (proportional_band_b == 16'h0000) ||
                   (integral_time_a == 16'h0000) || (integral_time_b == 16'h0000));
  assign cond[4] = both_inputs_used && ((first_input_unit != second_input_unit) ||
                   (first_input_decimal_point != second_input_decimal_point));
  assign cond[5] = (secondary_output_function == FCR_SECONDARY_OUTPUT_FUNCTION_ALARM2) &&
                   (second_alarm_function == FCR_ALM_NONE);
  assign cond[6] = (first_alarm_function == FCR_ALM_DWELL_TIMER) &&
                   (second_alarm_function == FCR_ALM_DWELL_TIMER);
  assign cond[7] = 1'b0;
  assign cond[8] = tune_fault;
  assign cond[9] = nvm_fault;
  assign cond[10] = second_broken;
  assign cond[11] = first_broken;
  assign cond[12] = adc_fault;
  assign cond[15:13] = 3'h0;

  // Lowest code number first.
  assign next_error_code =
    cond[0] ? FCR_ERR_PV_SP_FIRST :
    cond[1] ? FCR_ERR_PV_SP_SECOND :
    cond[2] ? FCR_ERR_PV_DIFF :
    cond[3] ? FCR_ERR_COOLING :
    cond[4] ? FCR_ERR_UNITS :
    cond[5] ? FCR_ERR_ALARM2_NONE :
    cond[6] ? FCR_ERR_DWELL_BOTH :
    cond[8] ? FCR_ERR_TUNE_FAIL :
    cond[9] ? FCR_ERR_NVM_WRITE :
    cond[10] ? FCR_ERR_SENSOR2 :
    cond[11] ? FCR_ERR_SENSOR1 :
    cond[12] ? FCR_ERR_ADC : FCR_ERR_NONE;

  // Tuning and nonvolatile failures are events, so they are latched until
  // acknowledged; a new failure in the acknowledge cycle is kept.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tune_fault <= 1'b0;
      nvm_fault <= 1'b0;
    end else begin
      tune_fault <= (tune_done && (tune_failed || tune_pid_out_of_range)) ||
                    (tune_fault && !fault_ack);
      nvm_fault <= (nvm_write_done && !nvm_write_ok) || (nvm_fault && !fault_ack);
    end
  end

  // Setup and sensor codes track their causes every cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      error_code <= FCR_ERR_NONE;
      error_active <= 1'b0;
      secondary_alarm_drive <= 1'b0;
    end else begin
      error_code <= next_error_code;
      error_active <= (next_error_code != FCR_ERR_NONE);
      secondary_alarm_drive <= (secondary_output_function == FCR_SECONDARY_OUTPUT_FUNCTION_ALARM2) &&
                               (second_alarm_function != FCR_ALM_NONE) &&
                               second_alarm_active;
    end
  end

  fcr_break_detect #(
    .FILTER_CYCLES(BREAK_FILTER_CYCLES)
  ) u_first_break (
    .sys_clk(sys_clk),
    .rst(rst),
    .mode(first_measurement_input_mode),
    .level(first_measurement_input_level),
    .open_circuit(first_measurement_input_open),
    .broken(first_broken)
  );

  // Filter is a quarter of the response limit, so detection stays in time.
  fcr_break_detect #(
    .FILTER_CYCLES(BREAK_FILTER_CYCLES)
  ) u_second_break (
    .sys_clk(sys_clk),
    .rst(rst),
    .mode(second_measurement_input_mode),
    .level(second_measurement_input_level),
    .open_circuit(second_measurement_input_open),
    .broken(second_broken)
  );

  // Age of an open circuit on the second input, to time the filter's answer.
  always_ff @(posedge sys_clk) begin
    if (rst || !second_measurement_input_open ||
        (second_measurement_input_mode != FCR_MODE_OPEN_DETECT)) begin
      second_open_age <= '0;
    end else if (second_open_age != 24'hffffff) begin
      second_open_age <= second_open_age + 24'h000001;
    end
  end

  fcr_comm_check u_comm (
    .sys_clk(sys_clk),
    .rst(rst),
    .req_valid(req_valid),
    .req_function(req_function),
    .req_address(req_address),
    .req_is_write(req_is_write),
    .reg_exists(reg_exists),
    .reg_read_only(reg_read_only),
    .reg_protected(reg_protected),
    .value_in_range(value_in_range),
    .resp_valid(comm_resp_valid),
    .write_enable(comm_write_enable),
    .resp_code(comm_error_code)
  );

  a_pv_sp_first: assert property (@(posedge sys_clk) disable iff (rst)
    cond[0] |=> error_code == FCR_ERR_PV_SP_FIRST) else $error("code 1 missing");
  a_pv_sp_second: assert property (@(posedge sys_clk) disable iff (rst)
    !cond[0] && cond[1] |=> error_code == FCR_ERR_PV_SP_SECOND) else $error("code 2 missing");
  a_cooling_check: assert property (@(posedge sys_clk) disable iff (rst)
    cond[3] |=> error_code <= FCR_ERR_COOLING && error_code != FCR_ERR_NONE)
    else $error("code 4 not raised");
  a_alarm2_none: assert property (@(posedge sys_clk) disable iff (rst)
    second_alarm_function == FCR_ALM_NONE |=> !secondary_alarm_drive)
    else $error("alarm drive with alarm none");
  a_dwell_both: assert property (@(posedge sys_clk) disable iff (rst)
    cond[6] |=> error_code != FCR_ERR_NONE && error_code <= FCR_ERR_DWELL_BOTH)
    else $error("code 7 not raised");
  a_tune_latch: assert property (@(posedge sys_clk) disable iff (rst)
    tune_done && tune_failed |=> tune_fault ##1 (tune_fault || $past(fault_ack)))
    else $error("tuning failure lost");
  a_adc_fault: assert property (@(posedge sys_clk) disable iff (rst)
    adc_fault |=> error_code != FCR_ERR_NONE && error_code <= FCR_ERR_ADC)
    else $error("converter fault not reported");
  a_auto_clear: assert property (@(posedge sys_clk) disable iff (rst)
    cond == 16'h0000 |=> error_code == FCR_ERR_NONE && !error_active)
    else $error("code did not clear");
  a_pv_diff: assert property (@(posedge sys_clk) disable iff (rst)
    cond[2] |=> error_code == FCR_ERR_PV_DIFF) else $error("code 3 missing");
  a_store_fail: assert property (@(posedge sys_clk) disable iff (rst)
    nvm_write_done && !nvm_write_ok |=> nvm_fault) else $error("store failure lost");
  a_second_break: assert property (@(posedge sys_clk) disable iff (rst)
    cond[10] && cond[9:0] == 10'h000 |=> error_code == FCR_ERR_SENSOR2)
    else $error("code 38 missing");
  a_first_break: assert property (@(posedge sys_clk) disable iff (rst)
    cond[11] && cond[10:0] == 11'h000 |=> error_code == FCR_ERR_SENSOR1)
    else $error("code 39 missing");
  a_break_in_time: assert property (@(posedge sys_clk) disable iff (rst)
    second_open_age > 24'(BREAK_FILTER_CYCLES) |-> second_broken)
    else $error("second input break detected late");
endmodule
`default_nettype wire

// *** verif/fcr_comm_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcr_comm_master (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command from the bench
  input wire logic go,
  input wire logic [7:0] cmd_func,
  input wire logic [15:0] cmd_addr,
  input wire logic [4:0] cmd_flags,
  // Request to the reporter
  output logic req_valid,
  output logic [7:0] req_function,
  output logic [15:0] req_address,
  output logic [4:0] req_flags,
  // Answer from the reporter
  input wire logic resp_valid,
  input wire logic resp_we,
  input wire logic [7:0] resp_code,
  output logic got,
  output logic got_we,
  output logic [7:0] got_code
);
  // Outside a request the fields toggle every cycle, so a late sample shows up as a wrong code.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {req_valid, req_function, req_address, req_flags} <= '0;
      {got, got_we, got_code} <= '0;
    end else begin
      req_valid <= go;
      req_function <= go ? cmd_func : ~req_function;
      req_address <= go ? cmd_addr : ~req_address;
      req_flags <= go ? cmd_flags : ~req_flags;
      {got, got_we, got_code} <= {resp_valid, resp_we, resp_code};
    end
  end
endmodule
`default_nettype wire

// *** verif/fcr_fault_code_reporter_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module fcr_fault_code_reporter_test;
  import fcr_pkg::*;
  localparam int FILT = 4;
  logic sys_clk, rst, direct, alm2_act, tune_done, tune_failed, tune_pid_bad, nvm_done, nvm_ok;
  logic open1, open2, adc_fault, fault_ack, go, req_valid, resp_valid, we, drive, err_act;
  logic got, got_we;
  logic [2:0] pv_sel, sp_sel, sec_fn;
  logic [15:0] pb_a, pb_b, ti_a, ti_b, lvl1, lvl2, cmd_addr, req_address;
  logic [3:0] unit1, unit2, alm1, alm2;
  logic [1:0] dec1, dec2, mode1, mode2;
  logic [7:0] cmd_func, req_function, comm_code, err, got_code;
  logic [4:0] cmd_flags, req_flags;
  int n_fail, n_checks;
  fcr_fault_code_reporter #(.BREAK_FILTER_CYCLES(FILT)) fcr_fault_code_reporter_inst (
    .sys_clk(sys_clk), .rst(rst),
    .process_value_source_select(pv_sel), .setpoint_source_select(sp_sel),
    .primary_output_function(3'h0), .primary_direct_action_choice(direct),
    .secondary_output_function(sec_fn), .proportional_band_a(pb_a), .proportional_band_b(pb_b),
    .integral_time_a(ti_a), .integral_time_b(ti_b),
    .first_input_unit(unit1), .second_input_unit(unit2),
    .first_input_decimal_point(dec1), .second_input_decimal_point(dec2),
    .first_alarm_function(alm1), .second_alarm_function(alm2), .second_alarm_active(alm2_act),
    .tune_done(tune_done), .tune_failed(tune_failed), .tune_pid_out_of_range(tune_pid_bad),
    .nvm_write_done(nvm_done), .nvm_write_ok(nvm_ok),
    .first_measurement_input_mode(mode1), .first_measurement_input_level(lvl1),
    .first_measurement_input_open(open1), .second_measurement_input_mode(mode2),
    .second_measurement_input_level(lvl2), .second_measurement_input_open(open2),
    .adc_fault(adc_fault), .req_valid(req_valid), .req_function(req_function),
    .req_address(req_address), .req_is_write(req_flags[4]), .reg_exists(req_flags[3]),
    .reg_read_only(req_flags[2]), .reg_protected(req_flags[1]), .value_in_range(req_flags[0]),
    .comm_resp_valid(resp_valid), .comm_write_enable(we), .comm_error_code(comm_code),
    .secondary_alarm_drive(drive), .error_code(err), .error_active(err_act), .fault_ack(fault_ack)
  );
  fcr_comm_master fcr_comm_master_inst (
    .sys_clk(sys_clk), .rst(rst), .go(go), .cmd_func(cmd_func), .cmd_addr(cmd_addr),
    .cmd_flags(cmd_flags), .req_valid(req_valid), .req_function(req_function),
    .req_address(req_address), .req_flags(req_flags), .resp_valid(resp_valid), .resp_we(we),
    .resp_code(comm_code), .got(got), .got_we(got_we), .got_code(got_code)
  );
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic settle(input logic [7:0] exp, input string what);
    tick(2);
    chk(err, exp, what);
    chk(8'(err_act), 8'(exp != 8'h00), what);
  endtask
  task automatic defaults;
    {pv_sel, sp_sel, sec_fn, direct} <= {FCR_SEL_FIRST, 3'h4, 3'h0, 1'b0};
    {pb_a, pb_b, ti_a, ti_b} <= {4{16'h0010}};
    {unit1, unit2, dec1, dec2} <= {4'h1, 4'h1, 2'h1, 2'h1};
    {alm1, alm2, alm2_act, adc_fault} <= {FCR_ALM_NONE, FCR_ALM_NONE, 2'h0};
    {tune_done, tune_failed, tune_pid_bad, nvm_done, nvm_ok, fault_ack} <= 6'h02;
    {mode1, lvl1, open1, mode2, lvl2, open2} <= {2'h3, 16'h0, 1'b0, 2'h3, 16'h0, 1'b0};
  endtask
  task automatic evt(input logic [4:0] v);
    @(posedge sys_clk);
    {tune_done, tune_failed, tune_pid_bad, nvm_done, nvm_ok} <= v;
    @(posedge sys_clk);
    {tune_done, nvm_done} <= 2'h0;
  endtask
  task automatic ack;
    @(posedge sys_clk);
    fault_ack <= 1'b1;
    @(posedge sys_clk);
    fault_ack <= 1'b0;
  endtask
  task automatic t_setup;
    logic [13:0] tbl [8];
    tbl = '{{3'h0, 3'h0, 8'h01}, {3'h1, 3'h1, 8'h02}, {3'h2, 3'h0, 8'h03}, {3'h3, 3'h1, 8'h03},
            {3'h2, 3'h3, 8'h00}, {3'h0, 3'h1, 8'h00}, {3'h3, 3'h4, 8'h00}, {3'h4, 3'h4, 8'h00}};
    foreach (tbl[i]) begin
      @(posedge sys_clk);
      {pv_sel, sp_sel} <= tbl[i][13:8];
      settle(tbl[i][7:0], "source pair");
    end
    @(posedge sys_clk);
    {pv_sel, sec_fn, direct} <= {FCR_SEL_FIRST, FCR_SECONDARY_OUTPUT_FUNCTION_COOLING, 1'b1};
    settle(8'h04, "cooling with direct primary");
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      {pb_a, pb_b, ti_a, ti_b, direct} <= {{4{16'h0010}} & ~(64'hffff << (16 * i)), 1'b0};
      settle(i < 4 ? 8'h04 : 8'h00, "cooling with zero term");
    end
    @(posedge sys_clk);
    {sp_sel, sec_fn, unit2} <= {FCR_SEL_SECOND, 3'h0, 4'h2};
    settle(8'h05, "unit mismatch");
    for (int a = 2; a < 6; a++) begin
      @(posedge sys_clk);
      {sp_sel, unit2, dec2} <= {3'h4, 4'h1, 2'h2};
      {alm1, alm2} <= a[0] ? {4'(a), 4'h0} : {4'h0, 4'(a)};
      settle(8'h05, "decimal mismatch with alarm");
    end
    @(posedge sys_clk);
    {alm1, alm2, pv_sel} <= {8'h00, FCR_SEL_DIFF12};
    settle(8'h05, "decimal mismatch with difference");
    @(posedge sys_clk);
    sp_sel <= FCR_SEL_FIRST;
    settle(8'h03, "lower code wins");
    @(posedge sys_clk);
    defaults();
    $display("setup test done");
  endtask
  task automatic t_alarm;
    @(posedge sys_clk);
    {sec_fn, alm2_act} <= {FCR_SECONDARY_OUTPUT_FUNCTION_ALARM2, 1'b1};
    settle(8'h06, "alarm output without function");
    chk(8'(drive), 8'h00, "alarm drive without function");
    @(posedge sys_clk);
    alm2 <= FCR_ALM_DIFF_HIGH;
    settle(8'h00, "alarm output with function");
    chk(8'(drive), 8'h01, "alarm drive with function");
    @(posedge sys_clk);
    {sec_fn, alm1, alm2} <= {3'h0, FCR_ALM_DWELL_TIMER, FCR_ALM_DWELL_TIMER};
    settle(8'h07, "dwell timer twice");
    @(posedge sys_clk);
    alm2 <= FCR_ALM_NONE;
    settle(8'h00, "dwell timer once");
    $display("alarm test done");
  endtask
  task automatic t_events;
    // Sources are left alone while tuning runs, or its result would mean nothing.
    evt(5'b11001);
    settle(8'h1a, "tuning failed");
    tick(5);
    settle(8'h1a, "tuning failure holds");
    ack();
    settle(8'h00, "tuning failure cleared");
    evt(5'b10101);
    @(posedge sys_clk);
    sp_sel <= FCR_SEL_FIRST;
    settle(8'h01, "setup beats tuning");
    @(posedge sys_clk);
    sp_sel <= 3'h4;
    settle(8'h1a, "tuning gains out of range");
    ack();
    evt(5'b10001);
    settle(8'h00, "tuning succeeded");
    evt(5'b00010);
    settle(8'h1d, "store write failed");
    ack();
    evt(5'b00011);
    settle(8'h00, "store write succeeded");
    @(posedge sys_clk);
    adc_fault <= 1'b1;
    settle(8'h28, "converter fault");
    @(posedge sys_clk);
    adc_fault <= 1'b0;
    settle(8'h00, "converter recovered");
    $display("event test done");
  endtask
  task automatic t_sensor;
    logic [45:0] tbl [10];
    tbl = '{{2'h1, 16'h3e7, 1'b0, 2'h3, 16'h0, 1'b0, 8'h27},
            {2'h1, 16'h3e8, 1'b0, 2'h3, 16'h0, 1'b0, 8'h00},
            {2'h2, 16'h0f9, 1'b0, 2'h3, 16'h0, 1'b0, 8'h27},
            {2'h2, 16'h0fa, 1'b0, 2'h3, 16'h0, 1'b0, 8'h00},
            {2'h0, 16'h0, 1'b1, 2'h3, 16'h0, 1'b0, 8'h27},
            {2'h3, 16'h0, 1'b1, 2'h3, 16'h0, 1'b0, 8'h00},
            {2'h3, 16'h0, 1'b0, 2'h1, 16'h3e7, 1'b0, 8'h26},
            {2'h3, 16'h0, 1'b0, 2'h2, 16'h0f9, 1'b0, 8'h26},
            {2'h0, 16'h0, 1'b1, 2'h0, 16'h0, 1'b1, 8'h26},
            {2'h3, 16'h0, 1'b0, 2'h3, 16'h0, 1'b0, 8'h00}};
    foreach (tbl[i]) begin
      @(posedge sys_clk);
      {mode1, lvl1, open1, mode2, lvl2, open2} <= tbl[i][45:8];
      tick(FILT + 1);
      settle(tbl[i][7:0], "sensor break");
    end
    $display("sensor test done");
  endtask
  task automatic t_comm;
    logic [37:0] tbl [13];
    int k;
    tbl = '{{8'h04, 16'h10, 5'h1f, 9'h14}, {8'h03, 16'h80, 5'h0f, 9'h16},
            {8'h03, 16'h7f, 5'h01, 9'h18}, {8'h06, 16'h10, 5'h1d, 9'h1c},
            {8'h06, 16'h10, 5'h1b, 9'h1c}, {8'h06, 16'h10, 5'h18, 9'h1e},
            {8'h06, 16'h7f, 5'h19, 9'h01}, {8'h10, 16'h00, 5'h19, 9'h01},
            {8'h03, 16'h10, 5'h0d, 9'h00},
            {8'h00, 16'h200, 5'h00, 9'h14}, {8'h06, 16'h100, 5'h10, 9'h16},
            {8'h06, 16'h10, 5'h16, 9'h18}, {8'h03, 16'h10, 5'h08, 9'h00}};
    foreach (tbl[i]) begin
      @(posedge sys_clk);
      {go, cmd_func, cmd_addr, cmd_flags} <= {1'b1, tbl[i][37:9]};
      @(posedge sys_clk);
      go <= 1'b0;
      for (k = 0; k < 8 && got !== 1'b1; k++) tick(1);
      if (k == 8) begin
        chk(8'h00, 8'h01, "no answer to a request");
        close_out();
      end
      chk(8'(k), 8'h02, "answer latency");
      chk(got_code, tbl[i][8:1], "comm code");
      chk(8'(got_we), 8'(tbl[i][0]), "comm write enable");
    end
    $display("comm test done");
  endtask
  initial begin
    rst = 1'b1;
    {go, cmd_func, cmd_addr, cmd_flags} = '0;
    n_fail = 0;
    n_checks = 0;
    defaults();
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    settle(8'h00, "after reset");
    t_setup();
    t_alarm();
    t_events();
    t_sensor();
    t_comm();
    close_out();
  end
endmodule
`default_nettype wire
